// ### crtcr_bank.sv
/*
 * Configuration register bank: clock tuning, reference edge position,
 * two full-scale settings, reference source and timestamp control.
 * Assumes a master that issues one-cycle strobes synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "crtcr_regs.svh"

module crtcr_bank (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic [7:0]          reg_addr,
    input  wire crtcr_pkg::crtcr_byte_t reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire logic                edge_capture,
    input  wire crtcr_pkg::crtcr_pos_t edge_position_in,
    output logic                     feedback_gain_high,
    output logic                     supply_noise_suppress_en,
    output logic      [1:0]          sample_clock_delay_sel,
    output logic                     sample_delay_onehot_ok,
    output crtcr_pkg::crtcr_fs_t     input_a_fullscale,
    output crtcr_pkg::crtcr_fs_t     input_b_fullscale,
    output logic                     input_a_below_min,
    output logic                     input_b_below_min,
    output logic                     reference_source_select,
    output logic                     timestamp_receiver_en,
    output logic                     timestamp_dc_coupled_mode,
    output logic      [3:0]          reference_delay_choice,
    output logic                     reference_window_fine,
    output logic                     auto_ref_cal_allowed
);
    import crtcr_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    crtcr_byte_t clk_tune_q;
    crtcr_fs_t   fsa_q;
    crtcr_fs_t   fsb_q;
    crtcr_byte_t ref_src_q;
    crtcr_byte_t timestamp_input_q;
    crtcr_byte_t ref_ctrl_q;
    crtcr_pos_t  pos_q;
    crtcr_byte_t rdata_q;
    crtcr_byte_t rdata_d;

    // ****************************************
    // write decode
    // ****************************************
    // one select per byte; reserved bits are stored, so a plain byte load suffices
    wire wr_clk   = reg_wr && (reg_addr == `CRTCR_OFF_CLK_TUNE);
    wire wr_fsa_l = reg_wr && (reg_addr == `CRTCR_OFF_FSA_LO);
    wire wr_fsa_h = reg_wr && (reg_addr == `CRTCR_OFF_FSA_HI);
    wire wr_fsb_l = reg_wr && (reg_addr == `CRTCR_OFF_FSB_LO);
    wire wr_fsb_h = reg_wr && (reg_addr == `CRTCR_OFF_FSB_HI);
    wire wr_src   = reg_wr && (reg_addr == `CRTCR_OFF_REF_SRC);
    wire wr_ts    = reg_wr && (reg_addr == `CRTCR_OFF_TIMESTAMP_INPUT);
    wire wr_ref   = reg_wr && (reg_addr == `CRTCR_OFF_REF_CTRL);

    // configuration registers, reserved bits kept as written
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_tune_q <= `CRTCR_RST_CLK_TUNE;
            fsa_q      <= `CRTCR_RST_FS;
            fsb_q      <= `CRTCR_RST_FS;
            ref_src_q  <= `CRTCR_RST_BYTE;
            timestamp_input_q    <= `CRTCR_RST_BYTE;
            ref_ctrl_q <= `CRTCR_RST_BYTE;
        end else begin
            if (wr_clk)   clk_tune_q  <= reg_wdata;
            if (wr_fsa_l) fsa_q[7:0]  <= reg_wdata;
            if (wr_fsa_h) fsa_q[15:8] <= reg_wdata;
            if (wr_fsb_l) fsb_q[7:0]  <= reg_wdata;
            if (wr_fsb_h) fsb_q[15:8] <= reg_wdata;
            if (wr_src)   ref_src_q   <= reg_wdata;
            if (wr_ts)    timestamp_input_q     <= reg_wdata;
            if (wr_ref)   ref_ctrl_q  <= reg_wdata;
        end
    end

    // ****************************************
    // edge position capture
    // ****************************************
    // only the capture strobe loads it; bus writes have no path here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pos_q <= `CRTCR_RST_POS;
        end else if (edge_capture) begin
            pos_q <= edge_position_in;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            `CRTCR_OFF_CLK_TUNE: rdata_d = clk_tune_q;
            `CRTCR_OFF_POS0:     rdata_d = pos_q[7:0];
            `CRTCR_OFF_POS1:     rdata_d = pos_q[15:8];
            `CRTCR_OFF_POS2:     rdata_d = pos_q[23:16];
            `CRTCR_OFF_FSA_LO:   rdata_d = fsa_q[7:0];
            `CRTCR_OFF_FSA_HI:   rdata_d = fsa_q[15:8];
            `CRTCR_OFF_FSB_LO:   rdata_d = fsb_q[7:0];
            `CRTCR_OFF_FSB_HI:   rdata_d = fsb_q[15:8];
            `CRTCR_OFF_REF_SRC:  rdata_d = ref_src_q;
            `CRTCR_OFF_TIMESTAMP_INPUT:    rdata_d = timestamp_input_q;
            `CRTCR_OFF_REF_CTRL: rdata_d = ref_ctrl_q;
            default:             rdata_d = 8'h00;
        endcase
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (srst) rdata_q <= 8'h00;
        else      rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
    assign reg_rdata = rdata_q;

    // ****************************************
    // field outputs
    // ****************************************
    // all taken straight from register bits, so no glitches reach the analog side
    assign feedback_gain_high        = clk_tune_q[`CRTCR_BIT_FB_GAIN];
    assign supply_noise_suppress_en  = clk_tune_q[`CRTCR_BIT_NOISE_EN];
    assign sample_clock_delay_sel    = clk_tune_q[1:0];
    assign input_a_fullscale         = fsa_q;
    assign input_b_fullscale         = fsb_q;
    assign reference_source_select   = ref_src_q[`CRTCR_BIT_REF_BYP];
    assign timestamp_receiver_en     = timestamp_input_q[`CRTCR_BIT_TS_RECV];
    assign timestamp_dc_coupled_mode = timestamp_input_q[`CRTCR_BIT_TS_DC];
    assign reference_delay_choice    = ref_ctrl_q[3:0];
    assign reference_window_fine     = ref_ctrl_q[`CRTCR_BIT_FINE];

    // status flags registered so they too come from flip-flops
    logic onehot_q;
    logic a_low_q;
    logic b_low_q;
    logic cal_ok_q;
    wire  onehot_d = clk_tune_q[0] ^ clk_tune_q[1];
    wire  a_low_d  = fsa_q < `CRTCR_FS_MIN_CODE;
    wire  b_low_d  = fsb_q < `CRTCR_FS_MIN_CODE;
    wire  cal_ok_d = ref_ctrl_q[3:0] == 4'h0;

    // flags lag their field by one cycle; harmless for static settings
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            onehot_q <= 1'b1;
            a_low_q  <= 1'b0;
            b_low_q  <= 1'b0;
            cal_ok_q <= 1'b1;
        end else begin
            onehot_q <= onehot_d;
            a_low_q  <= a_low_d;
            b_low_q  <= b_low_d;
            cal_ok_q <= cal_ok_d;
        end
    end
    assign sample_delay_onehot_ok = onehot_q;
    assign input_a_below_min      = a_low_q;
    assign input_b_below_min      = b_low_q;
    assign auto_ref_cal_allowed   = cal_ok_q;

    // ****************************************
    // checks
    // ****************************************
    sequence clk_write_s;
        reg_wr && reg_addr == `CRTCR_OFF_CLK_TUNE;
    endsequence

    // write strobe aimed at one offset, the first step of the single-offset checks in the field writes group except ts_on_a
    sequence wr_at_s(logic [7:0] off);
        reg_wr && reg_addr == off;
    endsequence

    // read strobe aimed at one offset; the answer follows one edge later
    sequence rd_at_s(logic [7:0] off);
        reg_rd && reg_addr == off;
    endsequence

    // a write and, straight after it, a read of the same byte
    sequence clk_wr_rd_s;
        wr_at_s(`CRTCR_OFF_CLK_TUNE) ##1 rd_at_s(`CRTCR_OFF_CLK_TUNE);
    endsequence

    clk_tune_reset_a: assert property (@(posedge sys_clk)
        srst |=> clk_tune_q == 8'h11 && feedback_gain_high)
        else $error("clock tuning reset value wrong");

    delay_onehot_a: assert property (@(posedge sys_clk) disable iff (srst)
        !$past(srst) |-> sample_delay_onehot_ok == $onehot($past(sample_clock_delay_sel)))
        else $error("one-hot flag wrong");

    noise_bit_a: assert property (@(posedge sys_clk) disable iff (srst)
        clk_write_s |=> supply_noise_suppress_en == $past(reg_wdata[2]))
        else $error("noise suppress bit not written");

    pos_capture_a: assert property (@(posedge sys_clk) disable iff (srst)
        edge_capture ##1 (reg_rd && reg_addr == `CRTCR_OFF_POS2) |=>
        reg_rdata == $past(edge_position_in[23:16], 2))
        else $error("edge position not read back");

    pos_readonly_a: assert property (@(posedge sys_clk) disable iff (srst)
        !edge_capture |=> $stable(pos_q))
        else $error("edge position changed without capture");

    fsa_reset_a: assert property (@(posedge sys_clk)
        srst |=> input_a_fullscale == 16'hA000)
        else $error("input A reset value wrong");

    fsb_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr == `CRTCR_OFF_FSB_HI |=>
        input_b_fullscale[15:8] == $past(reg_wdata))
        else $error("input B high byte not written");

    below_min_a: assert property (@(posedge sys_clk) disable iff (srst)
        (fsa_q < 16'h2000) |=> input_a_below_min)
        else $error("low range flag missing");

    ts_recv_a: assert property (@(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr == `CRTCR_OFF_TIMESTAMP_INPUT && !reg_wdata[0] |=>
        !timestamp_receiver_en)
        else $error("timestamp receiver not disabled");

    read_latency_a: assert property (@(posedge sys_clk) disable iff (srst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");

    // ****************************************
    // reset values
    // ****************************************
    delay_reset_a: assert property (@(posedge sys_clk)
        srst |=> sample_clock_delay_sel == 2'h1 && !supply_noise_suppress_en)
        else $error("sample delay reset value wrong");

    fsb_reset_a: assert property (@(posedge sys_clk)
        srst |=> input_b_fullscale == 16'hA000)
        else $error("input B reset value wrong");

    range_reset_a: assert property (@(posedge sys_clk)
        srst |=> !input_a_below_min && !input_b_below_min)
        else $error("default range flagged as low");

    src_reset_a: assert property (@(posedge sys_clk)
        srst |=> !reference_source_select)
        else $error("reference source reset value wrong");

    ts_reset_a: assert property (@(posedge sys_clk)
        srst |=> !timestamp_receiver_en && !timestamp_dc_coupled_mode)
        else $error("timestamp control reset value wrong");

    ref_reset_a: assert property (@(posedge sys_clk)
        srst |=> ref_ctrl_q == 8'h00 && auto_ref_cal_allowed)
        else $error("reference delay reset value wrong");

    // ****************************************
    // field writes
    // ****************************************
    gain_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_CLK_TUNE) |=> feedback_gain_high == $past(reg_wdata[4]))
        else $error("feedback gain bit not written");

    delay_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_CLK_TUNE) |=> sample_clock_delay_sel == $past(reg_wdata[1:0]))
        else $error("sample delay field not written");

    pos_load_a: assert property (@(posedge sys_clk) disable iff (srst)
        edge_capture |=> pos_q == $past(edge_position_in))
        else $error("edge position not captured");

    pos_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr >= `CRTCR_OFF_POS0 && reg_addr <= `CRTCR_OFF_POS2 |=>
        pos_q == $past(edge_capture ? edge_position_in : pos_q))
        else $error("edge position taken from the bus");

    fsa_low_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_FSA_LO) |=> input_a_fullscale[7:0] == $past(reg_wdata))
        else $error("input A low byte not written");

    fsa_high_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_FSA_HI) |=> input_a_fullscale[15:8] == $past(reg_wdata))
        else $error("input A high byte not written");

    fsb_low_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_FSB_LO) |=> input_b_fullscale[7:0] == $past(reg_wdata))
        else $error("input B low byte not written");

    src_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_REF_SRC) |=> reference_source_select == $past(reg_wdata[0]))
        else $error("reference source bit not written");

    ts_on_a: assert property (@(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr == `CRTCR_OFF_TIMESTAMP_INPUT && reg_wdata[0] |=> timestamp_receiver_en)
        else $error("timestamp receiver not enabled");

    ts_dc_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_TIMESTAMP_INPUT) |=> timestamp_dc_coupled_mode == $past(reg_wdata[1]))
        else $error("dc-coupled mode bit not written");

    ref_choice_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_REF_CTRL) |=> reference_delay_choice == $past(reg_wdata[3:0]))
        else $error("reference delay choice not written");

    fine_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr_at_s(`CRTCR_OFF_REF_CTRL) |=> reference_window_fine == $past(reg_wdata[4]))
        else $error("fine window bit not written");

    // ****************************************
    // derived flags
    // ****************************************
    above_min_a: assert property (@(posedge sys_clk) disable iff (srst)
        (input_a_fullscale >= 16'h2000) |=> !input_a_below_min)
        else $error("input A flagged low above minimum");

    b_low_a: assert property (@(posedge sys_clk) disable iff (srst)
        (input_b_fullscale < 16'h2000) |=> input_b_below_min)
        else $error("input B low range flag missing");

    b_above_a: assert property (@(posedge sys_clk) disable iff (srst)
        (input_b_fullscale >= 16'h2000) |=> !input_b_below_min)
        else $error("input B flagged low above minimum");

    cal_block_a: assert property (@(posedge sys_clk) disable iff (srst)
        (reference_delay_choice != 4'h0) |=> !auto_ref_cal_allowed)
        else $error("auto calibration allowed with a delay chosen");

    cal_allow_a: assert property (@(posedge sys_clk) disable iff (srst)
        (reference_delay_choice == 4'h0) |=> auto_ref_cal_allowed)
        else $error("auto calibration blocked with zero choice");

    // ****************************************
    // read answers
    // ****************************************
    clk_readback_a: assert property (@(posedge sys_clk) disable iff (srst)
        clk_wr_rd_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("clock tuning byte not read back whole");

    pos_mid_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        rd_at_s(`CRTCR_OFF_POS1) |=> reg_rdata == $past(pos_q[15:8]))
        else $error("edge position middle byte not read");

    fs_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        rd_at_s(`CRTCR_OFF_FSA_HI) |=> reg_rdata == $past(input_a_fullscale[15:8]))
        else $error("input A high byte not read");

endmodule // crtcr_bank

// ### crtcr_pkg.sv
/*
 * Types for the clock, range, timestamp configuration bank.
 * Assumes the constants header is included by the design file.
 */
package crtcr_pkg;
    typedef logic [7:0]  crtcr_byte_t;
    typedef logic [15:0] crtcr_fs_t;
    typedef logic [23:0] crtcr_pos_t;
endpackage

// ### crtcr_regs.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * clock, range, timestamp configuration bank.
 * Assumes byte addressing on the plain register port.
 */
// Notes on behaviour
// - the clock tuning register resets to 0x11, gain bit 4 high and delay field one.
// - the sample clock delay field in bits 1:0 is one-hot, one bit picks the step.
// - bit 2 of the clock tuning register enables supply noise suppression.
// - a 24-bit status word reports where the reference edge fell against the clock.
// - the edge position word at 0x2C is read-only and writes leave it alone.
// - input A full-scale setting is 16 bits at 0x30 and resets to 0xA000.
// - input B full-scale setting is 16 bits at 0x32, resets to 0xA000, same mapping.
// - code 0x2000 means 500 mVpp, the lowest advised, lower codes still accepted.
// - code 0xA000 means 800 mVpp and 0xFFFF the full 1000 mVpp.
// - bit 0 of the reference source register bypasses the band-gap, reset 0x00.
// - bit 0 of timestamp control enables the receiver, clear means disabled.
// - bit 1 of timestamp control selects dc-coupled mode, reset 0x00.
// - a four-bit reference delay choice selects the delay, zero allows auto calibration.
// - the fine window bit makes the reported delay steps smaller.
`ifndef CRTCR_REGS_SVH
`define CRTCR_REGS_SVH

// ****************************************
// offsets
// ****************************************
`define CRTCR_OFF_CLK_TUNE   8'h2B
`define CRTCR_OFF_POS0       8'h2C
`define CRTCR_OFF_POS1       8'h2D
`define CRTCR_OFF_POS2       8'h2E
`define CRTCR_OFF_FSA_LO     8'h30
`define CRTCR_OFF_FSA_HI     8'h31
`define CRTCR_OFF_FSB_LO     8'h32
`define CRTCR_OFF_FSB_HI     8'h33
`define CRTCR_OFF_REF_SRC    8'h38
`define CRTCR_OFF_TIMESTAMP_INPUT      8'h3B
`define CRTCR_OFF_REF_CTRL   8'h29

// ****************************************
// reset values
// ****************************************
`define CRTCR_RST_CLK_TUNE   8'h11
`define CRTCR_RST_FS         16'hA000
`define CRTCR_RST_BYTE       8'h00
`define CRTCR_RST_POS        24'h000000

// ****************************************
// field positions
// ****************************************
`define CRTCR_BIT_FB_GAIN    4
`define CRTCR_BIT_NOISE_EN   2
`define CRTCR_BIT_TS_RECV    0
`define CRTCR_BIT_TS_DC      1
`define CRTCR_BIT_REF_BYP    0
`define CRTCR_BIT_FINE       4
`define CRTCR_FS_MIN_CODE    16'h2000

`endif

// ### tb_top.sv
/*
 * Self-checking bench for the clock, range, timestamp configuration bank.
 * Assumes crtcr_pkg is compiled first and the bank's own assertions are in place.
 */
`timescale 1ns/1ps

module tb_top;
    import crtcr_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic       sys_clk, srst, reg_wr, reg_rd, edge_capture;
    logic [7:0] reg_addr, reg_rdata;
    crtcr_byte_t reg_wdata;
    crtcr_pos_t edge_position_in;
    crtcr_fs_t  fs_a, fs_b;
    logic [1:0] delay_sel;
    logic [3:0] ref_choice;
    logic       gain_hi, noise_en, onehot_ok, a_low, b_low, ref_src, ts_en, ts_dc, fine, cal_ok;
    int         errors, n_compared;
    // reset table: address and value seen after any reset
    logic [7:0] rst_addr [11] = '{8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h33,
                                  8'h38, 8'h3B, 8'h29};
    logic [7:0] rst_val  [11] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h00, 8'hA0,
                                  8'h00, 8'h00, 8'h00};

    crtcr_bank crtcr_bank_inst (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .edge_capture(edge_capture), .edge_position_in(edge_position_in),
        .feedback_gain_high(gain_hi), .supply_noise_suppress_en(noise_en),
        .sample_clock_delay_sel(delay_sel), .sample_delay_onehot_ok(onehot_ok),
        .input_a_fullscale(fs_a), .input_b_fullscale(fs_b), .input_a_below_min(a_low),
        .input_b_below_min(b_low), .reference_source_select(ref_src),
        .timestamp_receiver_en(ts_en), .timestamp_dc_coupled_mode(ts_dc),
        .reference_delay_choice(ref_choice), .reference_window_fine(fine),
        .auto_ref_cal_allowed(cal_ok));

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    // case equality so an unknown never counts as a match
    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe; outputs settle one edge later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe, then drops to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 cmp("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
        @(posedge sys_clk);
        #1 cmp("reg_rdata idle", 24'h0, {16'h0, reg_rdata});
    endtask

    // derived flags lag the register by one more edge
    task automatic flag_wait();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic check_resets();
        for (int i = 0; i < 11; i++) rd(rst_addr[i], rst_val[i]);
        cmp("flags", 24'h6, {21'h0, onehot_ok, cal_ok, a_low});
        cmp("bits", 24'h0, {19'h0, noise_en, b_low, ref_src, ts_dc, fine});
        cmp("gain", 24'h1, {23'h0, gain_hi});
        cmp("delay", 24'h1, {22'h0, delay_sel});
        cmp("fs_a", 24'hA000, {8'h0, fs_a});
        cmp("fs_b", 24'hA000, {8'h0, fs_b});
        cmp("ts_en", 24'h0, {23'h0, ts_en});
    endtask

    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    // every expectation comes from the register table, never from the bank
    initial begin
        errors = 0; n_compared = 0;
        srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        edge_capture = 1'b0; edge_position_in = 24'h0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        check_resets();
        rd(8'h40, 8'h00);
        // clock tuning: reserved bits stored, fields mapped
        wr(8'h2B, 8'hEE);
        cmp("gain", 24'h0, {23'h0, gain_hi});
        cmp("noise", 24'h1, {23'h0, noise_en});
        cmp("delay", 24'h2, {22'h0, delay_sel});
        flag_wait();
        cmp("onehot", 24'h1, {23'h0, onehot_ok});
        rd(8'h2B, 8'hEE);
        wr(8'h2B, 8'h03);
        flag_wait();
        cmp("onehot", 24'h0, {23'h0, onehot_ok});
        wr(8'h2B, 8'h00);
        flag_wait();
        cmp("onehot", 24'h0, {23'h0, onehot_ok});
        // full-scale codes at and just below the minimum, and at the maximum
        wr(8'h30, 8'hFF);
        wr(8'h31, 8'h1F);
        flag_wait();
        cmp("fs_a", 24'h1FFF, {8'h0, fs_a});
        cmp("a_low", 24'h1, {23'h0, a_low});
        wr(8'h30, 8'h00);
        wr(8'h31, 8'h20);
        flag_wait();
        cmp("a_low", 24'h0, {23'h0, a_low});
        wr(8'h32, 8'hFF);
        wr(8'h33, 8'hFF);
        flag_wait();
        cmp("fs_b", 24'hFFFF, {8'h0, fs_b});
        cmp("b_low", 24'h0, {23'h0, b_low});
        rd(8'h31, 8'h20);
        rd(8'h32, 8'hFF);
        wr(8'h33, 8'h1F);
        flag_wait();
        cmp("b_low", 24'h1, {23'h0, b_low});
        // reference source and timestamp control
        wr(8'h38, 8'h81);
        cmp("ref_src", 24'h1, {23'h0, ref_src});
        rd(8'h38, 8'h81);
        wr(8'h3B, 8'h01);
        cmp("ts", 24'h1, {22'h0, ts_dc, ts_en});
        wr(8'h3B, 8'h02);
        cmp("ts", 24'h2, {22'h0, ts_dc, ts_en});
        // reference delay choice blocks auto calibration unless zero
        wr(8'h29, 8'h15);
        flag_wait();
        cmp("ref_choice", 24'h5, {20'h0, ref_choice});
        cmp("fine", 24'h1, {23'h0, fine});
        cmp("cal_ok", 24'h0, {23'h0, cal_ok});
        wr(8'h29, 8'h10);
        flag_wait();
        cmp("cal_ok", 24'h1, {23'h0, cal_ok});
        // edge position capture, later input ignored, writes refused
        @(posedge sys_clk);
        edge_capture <= 1'b1; edge_position_in <= 24'hABCDEF;
        @(posedge sys_clk);
        edge_capture <= 1'b0; edge_position_in <= 24'h5A5A5A;
        wr(8'h2C, 8'h55);
        wr(8'h2E, 8'h00);
        rd(8'h2C, 8'hEF);
        rd(8'h2D, 8'hCD);
        rd(8'h2E, 8'hAB);
        // capture, read, write and read again with no idle cycle between strobes
        @(posedge sys_clk);
        edge_capture <= 1'b1; edge_position_in <= 24'h123456;
        @(posedge sys_clk);
        edge_capture <= 1'b0; reg_rd <= 1'b1; reg_addr <= 8'h2E;
        @(posedge sys_clk);
        reg_rd <= 1'b0; reg_wr <= 1'b1; reg_addr <= 8'h2B; reg_wdata <= 8'h91;
        #1 cmp("pos_hi", 24'h12, {16'h0, reg_rdata});
        @(posedge sys_clk);
        reg_wr <= 1'b0; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 cmp("clk_tune", 24'h91, {16'h0, reg_rdata});
        // reset in mid-run restores every value
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        check_resets();
        finish_test();
    end
endmodule // tb_top
